// File: diag_frame_generator_consts.vh
// constants for the diagnostic frame generator: register map, reset values,
// frame layout and state codes.
// assumes inclusion by bare name from the design files.
`ifndef DIAG_FRAME_GENERATOR_CONSTS_VH
`define DIAG_FRAME_GENERATOR_CONSTS_VH

// ----------------------------------------------------------------------
// register addresses in the management map
// ----------------------------------------------------------------------
`define ADDR_GEN_ENABLE 16'h8020
`define ADDR_GEN_CONTROL 16'h8021
`define ADDR_GEN_CONTINUOUS 16'h8022
`define ADDR_GEN_INTERRUPT_ENABLE 16'h8023
`define ADDR_GEN_PAYLOAD_LENGTH 16'h8025
`define ADDR_GEN_GAP_LENGTH 16'h8026
`define ADDR_GEN_FRAME_COUNT_UPPER 16'h8027
`define ADDR_GEN_FRAME_COUNT_LOWER 16'h8028
`define ADDR_GEN_COMPLETION_FLAG 16'h8029

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define RST_PAYLOAD_LENGTH 16'h006B
`define RST_GAP_LENGTH 16'h000C
`define RST_COUNT_UPPER 16'h0000
`define RST_COUNT_LOWER 16'h0100
`define RST_PATTERN 3'h1
`define BIT_ENABLE 0
`define BIT_RESTART 3
`define PATTERN_MSB 2

// ----------------------------------------------------------------------
// payload patterns
// ----------------------------------------------------------------------
`define PAT_STOP 3'h0
`define PAT_RANDOM 3'h1
`define PAT_ZEROS 3'h2
`define PAT_ONES 3'h3
`define PAT_ALT55 3'h4
`define PAT_DESCEND 3'h5
`define BYTE_ALT55 8'h55
`define BYTE_ONES 8'hFF
`define BYTE_ZERO 8'h00
`define DESCEND_START 8'hFF

// ----------------------------------------------------------------------
// frame layout: 6 dest + 6 source + 2 length, then 4 check bytes
// ----------------------------------------------------------------------
`define HDR_LAST_IDX 16'h000D
`define HDR_TOP_IDX 4'hD
`define FCS_LAST_IDX 16'h0003
`define DST_ADDRESS 48'hFFFFFFFFFFFF
`define SRC_ADDRESS 48'h020000000001
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400

// ----------------------------------------------------------------------
// state codes
// ----------------------------------------------------------------------
`define ST_IDLE 3'h0
`define ST_HDR 3'h1
`define ST_DATA 3'h2
`define ST_FCS 3'h3
`define ST_GAP 3'h4

`endif

// File: gen_fifo.v
// small synchronous fifo between the frame generator and the phy side.
// assumes one clock; the reader may stall so the fifo really fills.
`timescale 1ns/1ps
`default_nettype none

module gen_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // honest flags straight from the fill count
  assign o_in_ready = (count_q != DEPTH[AW:0]);
  assign o_out_valid = (count_q != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage has no reset; only pointers and fill count need a defined value
  always @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= i_in_data;
    end
  end

  // pointers and fill count
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: diag_frame_generator.v
// diagnostic ethernet frame generator with its management registers.
// assumes a 16-bit register port on the device clock and a phy transmit
// side that takes one byte per cycle while i_phy_tx_ready is high.
`timescale 1ns/1ps
`default_nettype none
`include "diag_frame_generator_consts.vh"

// What this block does
// RULE_01 - completion raises the generator interrupt only when enable bit 0 is set
// RULE_02 - software must also set the subsystem mask bit to see the interrupt
// RULE_03 - interrupt condition latched high in a subsystem status bit
// RULE_04 - 16-bit payload length in bytes, resets to 0x6B
// RULE_05 - each frame adds 6 dest, 6 source, 2 length, 4 check bytes
// RULE_06 - idle gap between frames equals 16-bit gap setting, resets to 0xC
// RULE_07 - frame count is 32 bits from upper and lower halves, lower resets 0x100
// RULE_08 - programmed count is reloaded on every enable or restart
// RULE_09 - done flag bit 0 sets when all requested frames are produced
// RULE_10 - done flag stays high until software reads it
// RULE_11 - when enabled with diag clock on, generator feeds phy instead of mac
// RULE_12 - 3-bit pattern select picks payload; 000 stops after current frame
// RULE_13 - continuous mode runs forever, otherwise one burst then stop
// RULE_14 - writing restart bit 3 restarts generator, bit then self-clears
// RULE_15 - order is dest, source, length, data, then crc-32 over preceding bytes
module diag_frame_generator (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [15:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  input wire i_diag_clock_enable,
  input wire i_diag_interrupt_mask_bit,
  input wire i_status_read,
  output reg o_diag_interrupt_latched_status,
  output reg o_irq,
  input wire [7:0] i_mac_tx_data,
  input wire i_mac_tx_en,
  input wire i_phy_tx_ready,
  output reg [7:0] o_phy_tx_data,
  output reg o_phy_tx_en
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------

  // one byte of reflected crc-32, lsb first as on the wire
  function [31:0] crc32_byte;
    input [31:0] crc;
    input [7:0] d;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (c[0] ^ d[i])
          c = (c >> 1) ^ `CRC_POLY;
        else
          c = c >> 1;
      end
      crc32_byte = c;
    end
  endfunction

  // header byte by index: dest, source, length field msb first
  function [7:0] hdr_byte;
    input [3:0] idx;
    input [15:0] len;
    reg [111:0] h;
    reg [3:0] k;
    begin
      k = `HDR_TOP_IDX - idx;
      h = {`DST_ADDRESS, `SRC_ADDRESS, len} >> {k, 3'b000};
      hdr_byte = h[7:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  reg enable_q;
  reg [2:0] pattern_q;
  reg restart_q;
  reg continuous_q;
  reg irq_enable_q;
  reg [15:0] payload_len_q;
  reg [15:0] gap_len_q;
  reg [15:0] count_upper_q;
  reg [15:0] count_lower_q;
  reg done_q;
  reg [2:0] state_q;
  reg [15:0] idx_q;
  reg [31:0] frames_left_q;
  reg [31:0] crc_q;
  reg [15:0] lfsr_q;
  reg [7:0] descend_q;
  reg run_q;
  reg gen_on_prev_q;
  reg gen_sel_q;

  wire gen_on;
  wire go;
  wire [31:0] count_total;
  wire wr_hit_ctrl;
  wire rd_done;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [8:0] fifo_out_data;
  wire push;
  wire [31:0] crc_final;
  wire [7:0] fcs_byte;
  wire frame_end;
  wire last_frame;
  wire stop_after;
  wire burst_done;
  reg [7:0] byte_d;
  reg byte_en_d;

  // generator only runs with the diagnostic clock enabled too
  assign gen_on = enable_q && i_diag_clock_enable; // RULE_11
  // fresh start on enable edge or restart write
  assign go = gen_on && (!gen_on_prev_q || restart_q); // RULE_08 RULE_14
  assign count_total = {count_upper_q, count_lower_q}; // RULE_07
  assign wr_hit_ctrl = i_reg_wr && (i_reg_addr == `ADDR_GEN_CONTROL);
  assign rd_done = i_reg_rd && (i_reg_addr == `ADDR_GEN_COMPLETION_FLAG);
  assign push = (state_q != `ST_IDLE) && fifo_in_ready;
  assign crc_final = ~crc_q;
  assign fcs_byte = crc_final[{idx_q[1:0], 3'b000} +: 8]; // RULE_15
  assign frame_end = push && (state_q == `ST_FCS) && (idx_q == `FCS_LAST_IDX);
  assign last_frame = !continuous_q && (frames_left_q == 32'h00000001); // RULE_13
  assign stop_after = last_frame || (pattern_q == `PAT_STOP); // RULE_12
  assign burst_done = (frame_end && last_frame && !go) ||
                      (go && (count_total == 32'h00000000) && !continuous_q); // RULE_09

  // ----------------------------------------------------------------------
  // byte being offered to the fifo
  // ----------------------------------------------------------------------

  // payload choice per pattern; stop code keeps zeros for the frame in flight
  always @*
  begin
    byte_d = `BYTE_ZERO;
    byte_en_d = 1'b1;
    case (state_q)
      `ST_HDR: byte_d = hdr_byte(idx_q[3:0], payload_len_q); // RULE_05 RULE_15
      `ST_DATA:
      begin
        case (pattern_q) // RULE_12
          `PAT_RANDOM: byte_d = lfsr_q[7:0];
          `PAT_ONES: byte_d = `BYTE_ONES;
          `PAT_ALT55: byte_d = `BYTE_ALT55;
          `PAT_DESCEND: byte_d = descend_q;
          default: byte_d = `BYTE_ZERO;
        endcase
      end
      `ST_FCS: byte_d = fcs_byte; // RULE_05
      `ST_GAP: byte_en_d = 1'b0; // RULE_06
      default: byte_en_d = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------

  // software-written settings; restart clears itself the cycle after its write
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      enable_q <= 1'b0;
      pattern_q <= `RST_PATTERN;
      restart_q <= 1'b0;
      continuous_q <= 1'b0;
      irq_enable_q <= 1'b0;
      payload_len_q <= `RST_PAYLOAD_LENGTH; // RULE_04
      gap_len_q <= `RST_GAP_LENGTH; // RULE_06
      count_upper_q <= `RST_COUNT_UPPER; // RULE_07
      count_lower_q <= `RST_COUNT_LOWER; // RULE_07
    end
    else
    begin
      if (wr_hit_ctrl)
        restart_q <= i_reg_wdata[`BIT_RESTART];
      else
        restart_q <= 1'b0; // RULE_14
      if (i_reg_wr)
      begin
        case (i_reg_addr)
          `ADDR_GEN_ENABLE: enable_q <= i_reg_wdata[`BIT_ENABLE];
          `ADDR_GEN_CONTROL: pattern_q <= i_reg_wdata[`PATTERN_MSB:0];
          `ADDR_GEN_CONTINUOUS: continuous_q <= i_reg_wdata[`BIT_ENABLE];
          `ADDR_GEN_INTERRUPT_ENABLE: irq_enable_q <= i_reg_wdata[`BIT_ENABLE];
          `ADDR_GEN_PAYLOAD_LENGTH: payload_len_q <= i_reg_wdata; // RULE_04
          `ADDR_GEN_GAP_LENGTH: gap_len_q <= i_reg_wdata;
          `ADDR_GEN_FRAME_COUNT_UPPER: count_upper_q <= i_reg_wdata;
          `ADDR_GEN_FRAME_COUNT_LOWER: count_lower_q <= i_reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data, done flag, interrupt status
  // ----------------------------------------------------------------------

  // read data lands one cycle after the strobe; unmapped reads give zero
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 16'h0000;
      done_q <= 1'b0;
      o_diag_interrupt_latched_status <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      if (i_reg_rd)
      begin
        case (i_reg_addr)
          `ADDR_GEN_ENABLE: o_reg_rdata <= {15'h0000, enable_q};
          `ADDR_GEN_CONTROL: o_reg_rdata <= {12'h000, restart_q, pattern_q};
          `ADDR_GEN_CONTINUOUS: o_reg_rdata <= {15'h0000, continuous_q};
          `ADDR_GEN_INTERRUPT_ENABLE: o_reg_rdata <= {15'h0000, irq_enable_q};
          `ADDR_GEN_PAYLOAD_LENGTH: o_reg_rdata <= payload_len_q;
          `ADDR_GEN_GAP_LENGTH: o_reg_rdata <= gap_len_q;
          `ADDR_GEN_FRAME_COUNT_UPPER: o_reg_rdata <= count_upper_q;
          `ADDR_GEN_FRAME_COUNT_LOWER: o_reg_rdata <= count_lower_q;
          `ADDR_GEN_COMPLETION_FLAG: o_reg_rdata <= {15'h0000, done_q};
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
      // set beats the clear-on-read so a completion is never lost
      done_q <= burst_done || (done_q && !rd_done); // RULE_09 RULE_10
      o_diag_interrupt_latched_status <= (burst_done && irq_enable_q) ||
        (o_diag_interrupt_latched_status && !i_status_read); // RULE_01 RULE_03
      // mask lives in the subsystem block; software must set it as well
      o_irq <= o_diag_interrupt_latched_status && i_diag_interrupt_mask_bit; // RULE_02
    end
  end

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------

  // one byte per accepted fifo push; fifo back-pressure stalls everything
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= `ST_IDLE;
      idx_q <= 16'h0000;
      frames_left_q <= 32'h00000000;
      crc_q <= `CRC_INIT;
      lfsr_q <= `LFSR_SEED;
      descend_q <= `DESCEND_START;
      run_q <= 1'b0;
      gen_on_prev_q <= 1'b0;
    end
    else
    begin
      gen_on_prev_q <= gen_on;
      if (!gen_on)
      begin
        // disabling aborts at once; the mac path takes over
        state_q <= `ST_IDLE;
        run_q <= 1'b0;
      end
      else
      begin
        if (go)
        begin
          frames_left_q <= count_total; // RULE_08
          run_q <= continuous_q || (count_total != 32'h00000000);
        end
        case (state_q)
          `ST_IDLE:
          begin
            if (run_q && (pattern_q != `PAT_STOP))
            begin
              state_q <= `ST_HDR;
              idx_q <= 16'h0000;
              crc_q <= `CRC_INIT;
              descend_q <= `DESCEND_START;
            end
          end
          `ST_HDR:
          begin
            if (push)
            begin
              crc_q <= crc32_byte(crc_q, byte_d); // RULE_15
              idx_q <= idx_q + 16'h0001;
              if (idx_q == `HDR_LAST_IDX)
              begin
                idx_q <= 16'h0000;
                state_q <= (payload_len_q == 16'h0000) ? `ST_FCS : `ST_DATA;
              end
            end
          end
          `ST_DATA:
          begin
            if (push)
            begin
              crc_q <= crc32_byte(crc_q, byte_d);
              idx_q <= idx_q + 16'h0001;
              lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `LFSR_TAPS) : (lfsr_q >> 1);
              descend_q <= descend_q - 8'h01; // wraps 0 back to 255
              if (idx_q == (payload_len_q - 16'h0001)) // RULE_04
              begin
                idx_q <= 16'h0000;
                state_q <= `ST_FCS;
              end
            end
          end
          `ST_FCS:
          begin
            if (push)
            begin
              idx_q <= idx_q + 16'h0001;
              if (frame_end)
              begin
                idx_q <= 16'h0000;
                if (!continuous_q && !go)
                  frames_left_q <= frames_left_q - 32'h00000001; // RULE_13
                if (stop_after && !go)
                  run_q <= 1'b0;
                if (gap_len_q != 16'h0000)
                  state_q <= `ST_GAP;
                else if (stop_after && !go)
                  state_q <= `ST_IDLE;
                else
                begin
                  state_q <= `ST_HDR;
                  crc_q <= `CRC_INIT;
                  descend_q <= `DESCEND_START;
                end
              end
            end
          end
          `ST_GAP:
          begin
            if (push)
            begin
              idx_q <= idx_q + 16'h0001;
              if (idx_q == (gap_len_q - 16'h0001)) // RULE_06
              begin
                idx_q <= 16'h0000;
                crc_q <= `CRC_INIT;
                descend_q <= `DESCEND_START;
                state_q <= (run_q && (pattern_q != `PAT_STOP)) ? `ST_HDR : `ST_IDLE;
              end
            end
          end
          default: state_q <= `ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // byte fifo and transmit mux
  // ----------------------------------------------------------------------

  // four bytes of slack so a stalled phy does not lose a byte
  gen_fifo #(
    .WIDTH(9),
    .DEPTH(4),
    .AW(2)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_in_valid(state_q != `ST_IDLE),
    .o_in_ready(fifo_in_ready),
    .i_in_data({byte_en_d, byte_d}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_phy_tx_ready),
    .o_out_data(fifo_out_data)
  );

  // phy source select; mac bytes pass through when generator is off
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      gen_sel_q <= 1'b0;
      o_phy_tx_data <= 8'h00;
      o_phy_tx_en <= 1'b0;
    end
    else
    begin
      gen_sel_q <= gen_on;
      if (gen_sel_q) // RULE_11
      begin
        if (i_phy_tx_ready)
        begin
          o_phy_tx_en <= fifo_out_valid && fifo_out_data[8];
          o_phy_tx_data <= fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
        end
      end
      else
      begin
        o_phy_tx_en <= i_mac_tx_en;
        o_phy_tx_data <= i_mac_tx_data;
      end
    end
  end

endmodule

`default_nettype wire

// File: diag_frame_generator_sva.sv
// assertions on the ports of the diagnostic frame generator
// assumes it is bound onto every diag_frame_generator instance
`timescale 1ns/1ps
`default_nettype none
`include "diag_frame_generator_consts.vh"
module diag_frame_generator_sva (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_diag_clock_enable,
  input wire logic i_diag_interrupt_mask_bit,
  input wire logic i_status_read,
  input wire logic o_diag_interrupt_latched_status,
  input wire logic o_irq,
  input wire logic [7:0] i_mac_tx_data,
  input wire logic i_mac_tx_en,
  input wire logic i_phy_tx_ready,
  input wire logic [7:0] o_phy_tx_data,
  input wire logic o_phy_tx_en
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // ----
  // registers: write, idle cycle, read gives the written word back; done flag reads zero above bit 0
  // ----
  property p_len_rw;
    i_reg_wr && i_reg_addr == `ADDR_GEN_PAYLOAD_LENGTH ##1 !i_reg_wr ##1 i_reg_rd &&
      !i_reg_wr && i_reg_addr == `ADDR_GEN_PAYLOAD_LENGTH |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  a_len_rw: assert property (p_len_rw) else $error("payload length readback");
  property p_cnt_rw;
    i_reg_wr && i_reg_addr == `ADDR_GEN_FRAME_COUNT_UPPER ##1 !i_reg_wr ##1 i_reg_rd &&
      !i_reg_wr && i_reg_addr == `ADDR_GEN_FRAME_COUNT_UPPER |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  a_cnt_rw: assert property (p_cnt_rw) else $error("count upper readback");
  property p_done_rsvd;
    i_reg_rd && i_reg_addr == `ADDR_GEN_COMPLETION_FLAG |=> o_reg_rdata[15:1] == 15'h0000;
  endproperty
  a_done_rsvd: assert property (p_done_rsvd) else $error("done upper bits set");
  // ----
  // interrupt path: a masked or cleared status never reaches the pin
  // ----
  property p_irq_mask;
    !i_diag_interrupt_mask_bit |=> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_irq_cause;
    $rose(o_irq) |-> $past(o_diag_interrupt_latched_status && i_diag_interrupt_mask_bit);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without status");
  property p_stat_hold;
    o_diag_interrupt_latched_status && !i_status_read |=> o_diag_interrupt_latched_status;
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status lost unread");
  // ----
  // transmit side
  // ----
  property p_mac_path;
    (!i_diag_clock_enable) [*3] ##0 i_phy_tx_ready |=> o_phy_tx_en == $past(i_mac_tx_en) &&
      (!o_phy_tx_en || o_phy_tx_data == $past(i_mac_tx_data));
  endproperty
  a_mac_path: assert property (p_mac_path) else $error("mac bytes not passed");
  // a stalled phy must see the same byte until it takes it
  property p_stall_hold;
    (i_diag_clock_enable && !i_reg_wr) [*4] ##0 !i_phy_tx_ready |=>
      $stable(o_phy_tx_data) && $stable(o_phy_tx_en);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("byte moved in stall");
  c_irq: cover property (o_irq);
  c_stall: cover property (!i_phy_tx_ready && o_phy_tx_en);
  c_done: cover property (i_reg_rd && i_reg_addr == `ADDR_GEN_COMPLETION_FLAG ##1 o_reg_rdata[0]);
endmodule
bind diag_frame_generator diag_frame_generator_sva u_sva (.*);
`default_nettype wire

// File: phy_tx_model.sv
// phy transmit side: takes one byte at each ready edge and splits frames
// assumes frames are separated by words with enable low
`timescale 1ns/1ps
`default_nettype none
module phy_tx_model (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_stall,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_en,
  output logic o_ready
);
  logic [7:0] frm[$];
  logic [7:0] cur[$];
  int nfrm;
  int idle;
  int gap;
  logic [3:0] cnt = 4'h0;
  // stall 8 of 16 edges: fills the fifo
  always @(negedge i_sys_clk)
  begin
    cnt <= cnt + 4'h1;
    o_ready <= !i_stall || !cnt[3];
  end
  // collect bytes; the idle run before a frame is its gap
  always @(posedge i_sys_clk)
    if (!i_resetn)
      cur = {};
    else if (o_ready && i_tx_en)
    begin
      if (cur.size() == 0) gap = idle;
      cur.push_back(i_tx_data);
      idle = 0;
    end
    else if (o_ready)
    begin
      if (cur.size() != 0) nfrm++;
      if (cur.size() != 0) frm = cur;
      cur = {};
      idle++;
    end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the diagnostic frame generator
// assumes the checker and the phy model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "diag_frame_generator_consts.vh"
module testbench;
  logic i_sys_clk, i_resetn, i_reg_wr, i_reg_rd, i_diag_clock_enable, i_status_read;
  logic i_diag_interrupt_mask_bit, i_mac_tx_en, stall, rdy, o_irq, o_phy_tx_en;
  logic o_diag_interrupt_latched_status;
  logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata, v;
  logic [7:0] i_mac_tx_data, o_phy_tx_data;
  int mismatches, checks;
  diag_frame_generator dut (.*, .i_phy_tx_ready(rdy));
  phy_tx_model m (.i_sys_clk, .i_resetn, .i_stall(stall), .i_tx_data(o_phy_tx_data),
    .i_tx_en(o_phy_tx_en), .o_ready(rdy));
  // ----
  // shared tasks
  // ----
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(negedge i_sys_clk) {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    @(negedge i_sys_clk) i_reg_wr = 1'b0;
  endtask
  task automatic rd(logic [15:0] a);
    @(negedge i_sys_clk) {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(negedge i_sys_clk) i_reg_rd = 1'b0;
    v = o_reg_rdata;
  endtask
  task automatic wait_frames(int n);
    for (int k = 0; k < 3000 && m.nfrm < n; k++) @(negedge i_sys_clk);
  endtask
  // quiet spell; frame total must not move
  task automatic settle(int n);
    repeat (100) @(negedge i_sys_clk);
    check(m.nfrm, n);
  endtask
  // restart from disabled: count reloads
  task automatic burst(logic [15:0] len, logic [15:0] gap, logic [15:0] n, logic [2:0] pat);
    wr(`ADDR_GEN_ENABLE, 16'h0000);
    wr(`ADDR_GEN_PAYLOAD_LENGTH, len);
    wr(`ADDR_GEN_GAP_LENGTH, gap);
    wr(`ADDR_GEN_FRAME_COUNT_LOWER, n);
    wr(`ADDR_GEN_CONTROL, {13'h0000, pat});
    m.nfrm = 0;
    wr(`ADDR_GEN_ENABLE, 16'h0001);
    wait_frames(n);
  endtask
  // last captured frame against layout, payload pattern and crc
  task automatic chk_frame(logic [15:0] len, logic [2:0] pat);
    logic [31:0] c;
    logic [7:0] e;
    int n;
    n = m.frm.size();
    check(n, len + 18);
    if (n != len + 18) return;
    c = `CRC_INIT;
    for (int i = 0; i < n - 4; i++)
    begin
      e = i < 6 ? 8'hFF : i < 12 ? 8'(`SRC_ADDRESS >> (8 * (11 - i))) : i == 12 ? len[15:8] :
        i == 13 ? len[7:0] : pat == 2 ? 8'h00 : pat == 3 ? 8'hFF : pat == 4 ? 8'h55 : 8'(269 - i);
      if (pat != 1 || i < 14) check(m.frm[i], e);
      c = c ^ {24'h000000, m.frm[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    end
    check({m.frm[n-1], m.frm[n-2], m.frm[n-3], m.frm[n-4]}, ~c);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    logic [15:0] exp[10] = '{0, 1, 0, 0, 0, 16'h006B, 16'h000C, 0, 16'h0100, 0};
    for (int i = 0; i < 10; i++)
    begin
      rd(16'h8020 + 16'(i));
      check(v, exp[i]);
    end
    wr(16'h8024, 16'hFFFF);
    rd(16'h8024);
    check(v, 16'h0000);
    wr(`ADDR_GEN_PAYLOAD_LENGTH, 16'h1234);
    rd(`ADDR_GEN_PAYLOAD_LENGTH);
    check(v, 16'h1234);
    wr(`ADDR_GEN_FRAME_COUNT_UPPER, 16'hABCD);
    rd(`ADDR_GEN_FRAME_COUNT_UPPER);
    check(v, 16'hABCD);
    wr(`ADDR_GEN_FRAME_COUNT_UPPER, 16'h0000);
  endtask
  task automatic t_irq();
    wr(`ADDR_GEN_INTERRUPT_ENABLE, 16'h0001);
    i_diag_interrupt_mask_bit = 1'b1;
    burst(16'h4, 16'h3, 16'h2, 3'h2);
    settle(2);
    chk_frame(16'h4, 3'h2);
    check(m.gap, 3);
    check({o_diag_interrupt_latched_status, o_irq}, 2'b11);
    rd(`ADDR_GEN_COMPLETION_FLAG);
    check(v, 16'h0001);
    rd(`ADDR_GEN_COMPLETION_FLAG);
    check(v, 16'h0000);
    @(negedge i_sys_clk) i_status_read = 1'b1;
    @(negedge i_sys_clk) i_status_read = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check({o_diag_interrupt_latched_status, o_irq}, 2'b00);
  endtask
  task automatic t_patterns();
    wr(`ADDR_GEN_INTERRUPT_ENABLE, 16'h0000);
    stall = 1'b1;
    for (int p = 1; p < 6; p++)
    begin
      burst(16'h6, 16'h2, 16'h1, 3'(p));
      settle(1);
      chk_frame(16'h6, 3'(p));
    end
    stall = 1'b0;
    check(o_diag_interrupt_latched_status, 0);
  endtask
  task automatic t_modes();
    wr(`ADDR_GEN_CONTINUOUS, 16'h0001);
    burst(16'h4, 16'h2, 16'h1, 3'h3);
    wait_frames(4);
    check(m.nfrm >= 4, 1);
    wr(`ADDR_GEN_CONTINUOUS, 16'h0000);
    burst(16'h4, 16'h2, 16'h1, 3'h3);
    settle(1);
    m.nfrm = 0;
    wr(`ADDR_GEN_CONTROL, 16'h000B);
    rd(`ADDR_GEN_CONTROL);
    check(v, 16'h0003);
    wait_frames(1);
    settle(1);
    wr(`ADDR_GEN_ENABLE, 16'h0000);
    wr(`ADDR_GEN_CONTROL, 16'h0000);
    rd(`ADDR_GEN_COMPLETION_FLAG);
    m.nfrm = 0;
    wr(`ADDR_GEN_ENABLE, 16'h0001);
    settle(0);
    rd(`ADDR_GEN_COMPLETION_FLAG);
    check(v, 16'h0000);
  endtask
  task automatic t_mac();
    wr(`ADDR_GEN_ENABLE, 16'h0000);
    @(negedge i_sys_clk) {i_mac_tx_en, i_mac_tx_data} = {1'b1, 8'hA5};
    repeat (3) @(negedge i_sys_clk);
    check({o_phy_tx_en, o_phy_tx_data}, 9'h1A5);
    i_diag_clock_enable = 1'b0;
    wr(`ADDR_GEN_ENABLE, 16'h0001);
    repeat (3) @(negedge i_sys_clk);
    check({o_phy_tx_en, o_phy_tx_data}, 9'h1A5);
    i_mac_tx_en = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // clock, reset, sequence and watchdog
  // ----
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd, i_status_read} = '0;
    {i_mac_tx_data, i_mac_tx_en, stall, i_diag_interrupt_mask_bit} = '0;
    {i_diag_clock_enable, i_resetn} = 2'b10;
    repeat (2) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    t_regs();
    t_irq();
    t_patterns();
    t_modes();
    t_mac();
    summarize();
  end
  // hang guard, well past the expected run
  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
